//--- core/ffp_pkg.sv
package ffp_pkg;
  localparam int          NSRC_DEF      = 32;
  localparam int          IDX_W         = 5;
  localparam int          VEC_W         = 32;
  localparam int          PRIO_W        = 3;
  localparam int          STK_DEPTH     = 8;
  localparam int          SP_W          = 4;
  localparam int          FAST_SRC      = 0;
  localparam int          SOURCE_TYPE_FIELD_W     = 2;
  localparam int          TYPE_EDGE_BIT = 0;
  localparam int          TYPE_HIGH_BIT = 1;
  localparam logic [1:0]  TYPE_LOW_LVL  = 2'h0;
  localparam logic [1:0]  TYPE_FALL     = 2'h1;
  localparam logic [1:0]  TYPE_HIGH_LVL = 2'h2;
  localparam logic [1:0]  TYPE_RISE     = 2'h3;
  localparam int          PROTECT_BIT   = 0;
  localparam logic        PROTECT_ON    = 1'h1;
  localparam logic [31:0] FAST_EXC_ADDR = 32'h0000001c;
  localparam logic [31:0] VEC_RST       = 32'h0;
  localparam logic [1:0]  TYPE_RST      = 2'h0;
  localparam logic [2:0]  PRIO_RST      = 3'h0;
endpackage

//--- core/ffp_vec_mem.sv
`timescale 1ns/1ns
`default_nettype none
module ffp_vec_mem
  import ffp_pkg::*;
#(
  parameter int DEPTH = NSRC_DEF,
  parameter int W     = VEC_W
)(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_addr,
  input  wire logic [W-1:0]     wr_data,
  // Read port
  input  wire logic [IDX_W-1:0] rd_addr,
  output logic      [W-1:0]     rd_data
);
  logic [W-1:0] mem_r [DEPTH];

  // Vector slots have a defined reset value so a read before setup is harmless.
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      if (!rst_b)
        mem_r[i] <= VEC_RST;
      else if (wr_en && (int'(wr_addr) == i))
        mem_r[i] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      rd_data <= VEC_RST;
    else if (int'(rd_addr) < DEPTH)
      rd_data <= mem_r[rd_addr];
    else
      rd_data <= VEC_RST;
  end
endmodule
`default_nettype wire

//--- core/ffp_fast_irq.sv
`timescale 1ns/1ns
`default_nettype none
module ffp_fast_irq #(
  parameter int NSRC = ffp_pkg::NSRC_DEF
)(
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  // Interrupt source pins
  input  wire logic [NSRC-1:0]               src_in,
  // Per-source setup writes, spurious vector and debug control
  input  wire logic [ffp_pkg::IDX_W-1:0]     reg_idx,
  input  wire logic                          svr_we,
  input  wire logic [ffp_pkg::VEC_W-1:0]     svr_wdata,
  input  wire logic                          smr_we,
  input  wire logic [ffp_pkg::SOURCE_TYPE_FIELD_W-1:0] smr_type,
  input  wire logic [ffp_pkg::PRIO_W-1:0]    smr_prio,
  input  wire logic                          spu_we,
  input  wire logic [ffp_pkg::VEC_W-1:0]     spu_wdata,
  input  wire logic                          dcr_we,
  input  wire logic [ffp_pkg::VEC_W-1:0]     dcr_wdata,
  // Bitwise command writes and end of interrupt
  input  wire logic [NSRC-1:0]               cmd_wdata,
  input  wire logic                          enable_cmd_we,
  input  wire logic                          disable_cmd_we,
  input  wire logic                          clear_cmd_we,
  input  wire logic                          ffen_we,
  input  wire logic                          ffdis_we,
  input  wire logic                          eoi_we,
  // Vector readout accesses
  input  wire logic                          fvr_rd,
  input  wire logic                          ivr_rd,
  input  wire logic                          ivr_wr,
  output logic      [ffp_pkg::VEC_W-1:0]     vec_rdata,
  output logic                               vec_rvalid,
  // Request lines and status
  output logic                               fast_irq_n,
  output logic                               normal_irq_n,
  output logic      [NSRC-1:0]               pending_flags,
  output logic      [NSRC-1:0]               mask_register,
  output logic      [NSRC-1:0]               fastforce_state,
  output logic      [ffp_pkg::IDX_W-1:0]     current_source_status,
  output logic                               protect_mode
);
  import ffp_pkg::*;

  if (NSRC < 2 || NSRC > (1 << IDX_W))
  begin : g_bad_nsrc
    $error("NSRC must lie between 2 and 32");
  end

  localparam logic [NSRC-1:0] NOT_FAST = ~(NSRC'(1));

  logic [NSRC-1:0]                s1_r, s2_r, s3_r;
  logic [NSRC-1:0][SOURCE_TYPE_FIELD_W-1:0] type_r;
  logic [NSRC-1:0][PRIO_W-1:0]    prio_r;
  logic [VEC_W-1:0]               spu_r, slot0_r, mem_rdata;
  logic [STK_DEPTH-1:0][PRIO_W-1:0] stk_lvl_r;
  logic [STK_DEPTH-1:0][IDX_W-1:0]  stk_num_r;
  logic [SP_W-1:0]                sp_r, sp_m1, sp_m2;
  logic                           mem_valid_r, rd_go_r, rd_spu_r;
  logic [IDX_W-1:0]               mem_src_r;
  logic [PRIO_W-1:0]              mem_lvl_r, cur_lvl;
  logic [NSRC-1:0]                act_lvl, edge_hit, edge_mask, clr, pend_nxt, elig, frc_edge_pend;
  logic [IDX_W+PRIO_W:0]          pick;
  logic                           higher, fiq_req, do_push, do_pop, idx_ok;
  logic [IDX_W-1:0]               push_src, rd_addr;
  logic [PRIO_W-1:0]              push_lvl;

  // Highest priority among eligible sources; the lowest index wins a tie.
  function automatic logic [IDX_W+PRIO_W:0] ffp_pick(
    input logic [NSRC-1:0]              el,
    input logic [NSRC-1:0][PRIO_W-1:0]  pr
  );
    logic              found;
    logic [IDX_W-1:0]  bidx;
    logic [PRIO_W-1:0] bpr;
    found = 1'b0;
    bidx  = '0;
    bpr   = '0;
    for (int i = 0; i < NSRC; i++)
    begin
      if (el[i] && (!found || pr[i] > bpr))
      begin
        found = 1'b1;
        bidx  = IDX_W'(i);
        bpr   = pr[i];
      end
    end
    return {found, bidx, bpr};
  endfunction

  // Source pins are synchronised before any detection logic looks at them.
  // They reset high, the idle level of the reset source type, so no false edge follows reset.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end
    else
    begin
      s1_r <= src_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign idx_ok = int'(reg_idx) < NSRC;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      type_r <= {NSRC{TYPE_RST}};
      prio_r <= {NSRC{PRIO_RST}};
    end
    else if (smr_we && idx_ok)
    begin
      type_r[reg_idx] <= smr_type;
      prio_r[reg_idx] <= smr_prio;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      spu_r        <= VEC_RST;
      slot0_r      <= VEC_RST;
      protect_mode <= 1'b0;
    end
    else
    begin
      if (spu_we)
        spu_r <= spu_wdata;
      if (svr_we && reg_idx == IDX_W'(FAST_SRC))
        slot0_r <= svr_wdata;
      if (dcr_we)
        protect_mode <= (dcr_wdata[PROTECT_BIT] == PROTECT_ON);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      mask_register   <= '0;
      fastforce_state <= '0;
    end
    else
    begin
      // Disable wins over enable when both commands land together.
      if (enable_cmd_we || disable_cmd_we)
        mask_register <= (mask_register | (enable_cmd_we ? cmd_wdata : '0))
                         & ~(disable_cmd_we ? cmd_wdata : '0);
      if (ffen_we || ffdis_we)
        fastforce_state <= ((fastforce_state | (ffen_we ? cmd_wdata : '0))
                            & ~(ffdis_we ? cmd_wdata : '0)) & NOT_FAST;
    end
  end

  // Detection keeps working for forced sources; only the routing changes.
  always_comb
  begin
    for (int i = 0; i < NSRC; i++)
    begin
      act_lvl[i]   = type_r[i][TYPE_HIGH_BIT] ? s2_r[i] : ~s2_r[i];
      edge_hit[i]  = type_r[i][TYPE_HIGH_BIT] ? (s2_r[i] & ~s3_r[i])
                                              : (~s2_r[i] & s3_r[i]);
      edge_mask[i] = type_r[i][TYPE_EDGE_BIT];
    end
  end

  assign sp_m1   = sp_r - SP_W'(1);
  assign sp_m2   = sp_r - SP_W'(2);
  assign cur_lvl = stk_lvl_r[sp_m1[2:0]];
  assign elig    = pending_flags & mask_register & ~fastforce_state & NOT_FAST;
  assign frc_edge_pend = fastforce_state & pending_flags & edge_mask;
  assign pick    = ffp_pick(elig, prio_r);
  assign higher  = pick[IDX_W+PRIO_W] && (sp_r == '0 || pick[PRIO_W-1:0] > cur_lvl);

  // Protect mode defers push and acknowledge to the readout write.
  assign do_push  = protect_mode ? (ivr_wr && mem_valid_r) : (ivr_rd && higher);
  assign push_src = protect_mode ? mem_src_r : pick[IDX_W+PRIO_W-1:PRIO_W];
  assign push_lvl = protect_mode ? mem_lvl_r : pick[PRIO_W-1:0];
  assign do_pop   = eoi_we && !do_push && sp_r != '0;

  always_comb
  begin
    clr = clear_cmd_we ? cmd_wdata : '0;
    // A fast read never clears source 0 while any source is forced.
    if (fvr_rd && edge_mask[FAST_SRC] && fastforce_state == '0)
      clr[FAST_SRC] = 1'b1;
    // Forced sources are never eligible, so this acknowledge cannot clear one.
    if (do_push && !fastforce_state[push_src])
      clr[push_src] = 1'b1;
    // A new edge wins over a clear in the same cycle.
    pend_nxt = (edge_hit | (pending_flags & ~clr)) & edge_mask;
    pend_nxt = pend_nxt | (act_lvl & ~edge_mask);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      pending_flags <= '0;
    else
      pending_flags <= pend_nxt;
  end

  // Source 0 and every forced source drive the fast line.
  assign fiq_req = (pending_flags[FAST_SRC] & mask_register[FAST_SRC])
                   | (|(pending_flags & mask_register & fastforce_state));

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      fast_irq_n   <= 1'b1;
      normal_irq_n <= 1'b1;
    end
    else
    begin
      fast_irq_n   <= ~fiq_req;
      normal_irq_n <= ~higher;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      mem_valid_r <= 1'b0;
      mem_src_r   <= '0;
      mem_lvl_r   <= '0;
    end
    else if (ivr_rd && !fvr_rd)
    begin
      mem_valid_r <= higher;
      mem_src_r   <= pick[IDX_W+PRIO_W-1:PRIO_W];
      mem_lvl_r   <= pick[PRIO_W-1:0];
    end
    else if (ivr_wr)
      mem_valid_r <= 1'b0;
  end

  // A full stack refuses further pushes; an empty one ignores end of interrupt.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      sp_r                  <= '0;
      stk_lvl_r             <= '0;
      stk_num_r             <= '0;
      current_source_status <= '0;
    end
    else if (do_push && sp_r != SP_W'(STK_DEPTH))
    begin
      stk_lvl_r[sp_r[2:0]]  <= push_lvl;
      stk_num_r[sp_r[2:0]]  <= push_src;
      sp_r                  <= sp_r + SP_W'(1);
      current_source_status <= push_src;
    end
    else if (do_pop)
    begin
      sp_r                  <= sp_m1;
      current_source_status <= (sp_r == SP_W'(1)) ? '0 : stk_num_r[sp_m2[2:0]];
    end
  end

  assign rd_addr = fvr_rd ? IDX_W'(FAST_SRC) : pick[IDX_W+PRIO_W-1:PRIO_W];

  ffp_vec_mem #(
    .DEPTH (NSRC),
    .W     (VEC_W)
  ) u_vec_mem (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .wr_en   (svr_we && idx_ok),
    .wr_addr (reg_idx),
    .wr_data (svr_wdata),
    .rd_addr (rd_addr),
    .rd_data (mem_rdata)
  );

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      rd_go_r    <= 1'b0;
      rd_spu_r   <= 1'b0;
      vec_rdata  <= VEC_RST;
      vec_rvalid <= 1'b0;
    end
    else
    begin
      rd_go_r    <= fvr_rd || ivr_rd;
      rd_spu_r   <= ivr_rd && !fvr_rd && !higher;
      vec_rvalid <= rd_go_r;
      if (rd_go_r)
        vec_rdata <= rd_spu_r ? spu_r : mem_rdata;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_fvr_edge_clear: assert property (
    fvr_rd && edge_mask[FAST_SRC] && fastforce_state == '0 && !edge_hit[FAST_SRC]
    |=> !pending_flags[FAST_SRC])
    else $error("fast read did not clear edge source 0");
  chk_ff_keeps_src0: assert property (
    fvr_rd && fastforce_state != '0 && !clear_cmd_we && pending_flags[FAST_SRC]
    && edge_mask[FAST_SRC] |=> pending_flags[FAST_SRC])
    else $error("fast read cleared source 0 under forcing");
  chk_ff_enable_cmd: assert property (
    ffen_we && !ffdis_we |=> (fastforce_state & ($past(cmd_wdata) & NOT_FAST))
    == ($past(cmd_wdata) & NOT_FAST))
    else $error("fastforce enable not applied");
  chk_forced_fiq: assert property (
    |(pending_flags & mask_register & fastforce_state) |=> !fast_irq_n)
    else $error("forced source did not assert fast line");
  chk_fiq_idle: assert property (
    !fiq_req |=> fast_irq_n)
    else $error("fast line low without request");
  chk_forced_no_irq: assert property (
    elig == '0 |=> normal_irq_n)
    else $error("normal line low with only forced requests");
  chk_src0_pend: assert property (
    edge_mask[FAST_SRC] && !edge_hit[FAST_SRC] && !clr[FAST_SRC]
    |=> pending_flags[FAST_SRC] == $past(pending_flags[FAST_SRC]))
    else $error("source 0 pending changed by another source");
  chk_fvr_slot0: assert property (
    fvr_rd |-> ##2 (vec_rvalid && vec_rdata == $past(slot0_r, 2)))
    else $error("fast readout not slot 0");
  chk_ivr_forced: assert property (
    ivr_rd && !clear_cmd_we |=> (pending_flags & $past(frc_edge_pend)) == $past(frc_edge_pend))
    else $error("normal read cleared forced source");
  chk_protect_read: assert property (
    protect_mode && !ivr_wr && !eoi_we |=> sp_r == $past(sp_r)
    && current_source_status == $past(current_source_status))
    else $error("protect mode context changed without write");
  chk_protect_on: assert property (
    dcr_we |=> protect_mode == $past(dcr_wdata[PROTECT_BIT]))
    else $error("protect bit not taken");
  chk_normal_push: assert property (
    !protect_mode && ivr_rd && higher && sp_r != SP_W'(STK_DEPTH)
    |=> sp_r == $past(sp_r) + SP_W'(1))
    else $error("normal read did not stack");
  chk_mask_cmd: assert property (
    enable_cmd_we && cmd_wdata[FAST_SRC] && !disable_cmd_we |=> mask_register[FAST_SRC])
    else $error("fast source enable not applied");

  cov_forced_fiq: cover property (|fastforce_state ##1 !fast_irq_n);
  cov_protect_push: cover property (protect_mode && ivr_rd ##[1:8] ivr_wr && mem_valid_r);
  cov_spurious: cover property (ivr_rd && !higher ##2 vec_rvalid);
  cov_eoi_pop: cover property (do_pop);
endmodule
`default_nettype wire

//--- bench/ffp_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module ffp_core_model (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  // Request line and return from the fast handler
  input  wire logic                      fast_irq_n,
  input  wire logic                      fiq_return,
  // Fast vector readout access
  output logic                           fvr_rd,
  input  wire logic                      vec_rvalid,
  input  wire logic [ffp_pkg::VEC_W-1:0] vec_rdata,
  // Observed core state
  output logic      [ffp_pkg::VEC_W-1:0] pc,
  output logic                           fast_masked,
  output logic      [7:0]                taken
);
  import ffp_pkg::*;

  logic [VEC_W-1:0] link_r;
  logic             saved_mask_r;
  logic             wait_vec_r;

  // The core looks at the request line between instructions, on the falling edge.
  always @(negedge sys_clk)
  begin
    fvr_rd <= 1'b0;
    if (!rst_b)
    begin
      pc           <= 32'h00000100;
      link_r       <= 32'h00000000;
      fast_masked  <= 1'b0;
      saved_mask_r <= 1'b0;
      wait_vec_r   <= 1'b0;
      taken        <= 8'h00;
    end
    else if (fiq_return)
    begin
      pc          <= link_r;
      fast_masked <= saved_mask_r;
    end
    else if (!fast_irq_n && !fast_masked)
    begin
      saved_mask_r <= fast_masked;
      link_r       <= pc;
      pc           <= FAST_EXC_ADDR;
      fast_masked  <= 1'b1;
      fvr_rd       <= 1'b1;
      wait_vec_r   <= 1'b1;
      taken        <= taken + 8'h01;
    end
    else if (wait_vec_r && vec_rvalid)
    begin
      pc         <= vec_rdata;
      wait_vec_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- bench/fast_irq_forcing_protect_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) check(64'(g), 64'(e))
module fast_irq_forcing_protect_tb_top;
  import ffp_pkg::*;

  localparam logic [31:0] V0 = 32'h0000a000;
  localparam logic [31:0] V5 = 32'h0000b500;
  localparam logic [31:0] VS = 32'h0000e000;

  logic        sys_clk, rst_b, fiq_return, fvr_rd, vec_rvalid;
  logic [31:0] src_in, cmd_wdata, svr_wdata, spu_wdata, dcr_wdata, vec_rdata, pc, v;
  logic [31:0] pending_flags, mask_register, fastforce_state;
  logic [4:0]  reg_idx, current_source_status;
  logic [1:0]  smr_type;
  logic [2:0]  smr_prio;
  logic [7:0]  taken, n0;
  logic        svr_we, smr_we, spu_we, dcr_we, enable_cmd_we, disable_cmd_we;
  logic        clear_cmd_we, ffen_we, ffdis_we, eoi_we, ivr_rd, ivr_wr;
  logic        fast_irq_n, normal_irq_n, protect_mode, fast_masked;
  int          errors, n_checks;

  ffp_fast_irq dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .src_in(src_in), .reg_idx(reg_idx),
    .svr_we(svr_we), .svr_wdata(svr_wdata), .smr_we(smr_we), .smr_type(smr_type),
    .smr_prio(smr_prio), .spu_we(spu_we), .spu_wdata(spu_wdata), .dcr_we(dcr_we),
    .dcr_wdata(dcr_wdata), .cmd_wdata(cmd_wdata), .enable_cmd_we(enable_cmd_we),
    .disable_cmd_we(disable_cmd_we), .clear_cmd_we(clear_cmd_we), .ffen_we(ffen_we),
    .ffdis_we(ffdis_we), .eoi_we(eoi_we), .fvr_rd(fvr_rd), .ivr_rd(ivr_rd), .ivr_wr(ivr_wr),
    .vec_rdata(vec_rdata), .vec_rvalid(vec_rvalid), .fast_irq_n(fast_irq_n),
    .normal_irq_n(normal_irq_n), .pending_flags(pending_flags), .mask_register(mask_register),
    .fastforce_state(fastforce_state), .current_source_status(current_source_status),
    .protect_mode(protect_mode));

  ffp_core_model core_u (.sys_clk(sys_clk), .rst_b(rst_b), .fast_irq_n(fast_irq_n),
    .fiq_return(fiq_return), .fvr_rd(fvr_rd), .vec_rvalid(vec_rvalid),
    .vec_rdata(vec_rdata), .pc(pc), .fast_masked(fast_masked), .taken(taken));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Data strobes: 0 enable, 1 disable, 2 clear, 3 force on, 4 force off, 5 end of
  // interrupt, 6 vector readout write, 7 debug control, 8 spurious vector.
  task automatic cmd(input int k, input logic [31:0] d);
    @(negedge sys_clk);
    cmd_wdata = d;
    dcr_wdata = d;
    spu_wdata = d;
    case (k)
      0: enable_cmd_we = 1'b1;
      1: disable_cmd_we = 1'b1;
      2: clear_cmd_we = 1'b1;
      3: ffen_we = 1'b1;
      4: ffdis_we = 1'b1;
      5: eoi_we = 1'b1;
      6: ivr_wr = 1'b1;
      7: dcr_we = 1'b1;
      default: spu_we = 1'b1;
    endcase
    @(negedge sys_clk);
    {enable_cmd_we, disable_cmd_we, clear_cmd_we, ffen_we, ffdis_we} = '0;
    {eoi_we, ivr_wr, dcr_we, spu_we} = '0;
  endtask

  task automatic cfg(input logic [4:0] idx, input logic [1:0] ty, input logic [31:0] vec);
    @(negedge sys_clk);
    reg_idx = idx;
    smr_type = ty;
    svr_wdata = vec;
    smr_we = 1'b1;
    svr_we = 1'b1;
    @(negedge sys_clk);
    smr_we = 1'b0;
    svr_we = 1'b0;
  endtask

  task automatic rd_ivr(output logic [31:0] d);
    @(negedge sys_clk);
    ivr_rd = 1'b1;
    @(negedge sys_clk);
    ivr_rd = 1'b0;
    d = 'x;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge sys_clk);
      if (vec_rvalid === 1'b1)
      begin
        d = vec_rdata;
        break;
      end
    end
  endtask

  task automatic ret_fast;
    @(negedge sys_clk);
    fiq_return = 1'b1;
    @(negedge sys_clk);
    fiq_return = 1'b0;
  endtask

  task automatic edge5;
    @(negedge sys_clk);
    src_in[5] = 1'b0;
    tick(2);
    src_in[5] = 1'b1;
    tick(6);
  endtask

  initial
  begin
    #(8 * 20000);
    errors++;
    report_and_stop();
  end

  initial
  begin
    {rst_b, fiq_return, ivr_rd, svr_we, smr_we, spu_we, dcr_we, eoi_we, ivr_wr} = '0;
    {enable_cmd_we, disable_cmd_we, clear_cmd_we, ffen_we, ffdis_we} = '0;
    {cmd_wdata, svr_wdata, spu_wdata, dcr_wdata, reg_idx, smr_type} = '0;
    smr_prio = 3'h4;
    // Every pin idles high, the inactive level of the reset source type.
    src_in = 32'hffffffff;
    errors = 0;
    n_checks = 0;
    repeat (12) @(negedge sys_clk);
    rst_b = 1'b1;
    tick(3);
    `CHK(pending_flags, 0);
    `CHK({mask_register, fastforce_state}, 0);
    `CHK({fast_irq_n, normal_irq_n, protect_mode, current_source_status}, 8'hc0);
    cfg(5'h5, TYPE_RISE, V5);
    cfg(5'h6, TYPE_HIGH_LVL, 32'h0000b600);
    src_in[6:5] = 2'b00;
    cmd(8, VS);
    cmd(0, 32'h00000061);
    `CHK(mask_register, 32'h00000061);
    rd_ivr(v);
    `CHK(v, VS);
    cmd(5, 0);
    // Every detection type of source 0, each handled by the core model.
    for (int t = 0; t < 4; t++)
    begin
      @(negedge sys_clk);
      src_in[0] = ~t[1];
      cfg(5'h0, 2'(t), V0);
      tick(6);
      `CHK(fast_irq_n, 1);
      n0 = taken;
      src_in[0] = t[1];
      tick(12);
      `CHK({taken, pc}, {n0 + 8'h01, V0});
      `CHK({fast_irq_n, pending_flags[0]}, {t[0], ~t[0]});
      src_in[0] = ~t[1];
      tick(6);
      `CHK(fast_irq_n, 1);
      ret_fast();
    end
    cmd(3, 32'h00000061);
    `CHK(fastforce_state, 32'h00000060);
    n0 = taken;
    @(negedge sys_clk);
    src_in[5] = 1'b1;
    tick(12);
    `CHK({taken, pc}, {n0 + 8'h01, V0});
    `CHK({fast_irq_n, normal_irq_n}, 2'h1);
    `CHK(pending_flags, 32'h00000020);
    rd_ivr(v);
    `CHK({v, pending_flags}, {VS, 32'h00000020});
    cmd(5, 0);
    @(negedge sys_clk);
    src_in[0] = 1'b0;
    tick(2);
    src_in[0] = 1'b1;
    tick(6);
    ret_fast();
    tick(10);
    `CHK({taken, pending_flags}, {n0 + 8'h02, 32'h00000021});
    cmd(2, 32'h00000021);
    tick(6);
    `CHK({fast_irq_n, pending_flags}, {1'b1, 32'h0});
    ret_fast();
    @(negedge sys_clk);
    src_in[6] = 1'b1;
    tick(10);
    `CHK({fast_irq_n, normal_irq_n}, 2'h1);
    src_in[6] = 1'b0;
    tick(8);
    `CHK(fast_irq_n, 1);
    ret_fast();
    cmd(4, 32'h00000060);
    `CHK(fastforce_state, 0);
    edge5();
    `CHK(normal_irq_n, 0);
    rd_ivr(v);
    `CHK({v, 27'h0, current_source_status}, {V5, 32'h5});
    `CHK(pending_flags, 0);
    cmd(5, 0);
    tick(2);
    `CHK(current_source_status, 0);
    cmd(7, 32'h00000001);
    `CHK(protect_mode, 1);
    edge5();
    rd_ivr(v);
    `CHK({v, 27'h0, current_source_status}, {V5, 32'h0});
    rd_ivr(v);
    `CHK({v, pending_flags}, {V5, 32'h00000020});
    cmd(6, 32'h00000000);
    `CHK({current_source_status, pending_flags}, {5'h5, 32'h0});
    cmd(5, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
